// file: logic/mpl_panel_top.v
// Machine panel, emergency stop, overtravel, beacon and reset key logic.
// Assumes pins are asynchronous, core signals share clk_sys, and a plain register port.
// Notes on behaviour
// - Auxiliary lock applies only in automatic, MDI or DNC mode.
// - Single block applies only in automatic, MDI or DNC mode.
// - Dry run applies only in automatic, MDI or DNC mode.
// - Dry run state frozen while a program executes.
// - Optional stop key toggles optional stop state and indicator in automatic, MDI or DNC mode only.
// - M01 with optional stop active halts until cycle start.
// - Emergency input open raises alarm and drops drive enable.
// - Emergency input acted on when ignore flag is 0.
// - Limit selector 10 separate, 01 combined, 00 or 11 off.
// - Separate mode checks minus and plus inputs of every axis.
// - Combined mode uses one input per axis (plus for X, minus for the others); motion direction unused.
// - XYZ alarm level: open input if polarity 1, closed if 0.
// - XYZ overtravel checked only when check bit set.
// - Fourth and fifth axis limits each need their enable bit.
// - Overtravel alarm clears only on reset key after input returns.
// - Yellow idle, green automatic running, red on any alarm.
// - Reset key acted on only when reset enable bit is 1.
// - Enabled reset in automatic mode resets and returns cursor.
`include "mpl_defines.vh"
module mpl_panel_top (
    clk_sys,
    rst_b,
    reg_addr,
    reg_wdata,
    reg_wr,
    reg_rd,
    reg_rdata,
    irq,
    mode_auto,
    mode_mdi,
    mode_dnc,
    prog_running,
    m01_exec,
    axis_dir_neg,
    key_aux_lock,
    key_single_block,
    key_dry_run,
    key_opt_stop,
    key_cycle_start,
    key_reset,
    ext_estop_in,
    x_minus_limit_in,
    x_plus_limit_in,
    y_minus_limit_in,
    y_plus_limit_in,
    z_minus_limit_in,
    z_plus_limit_in,
    axis4_minus_limit_in,
    axis4_plus_limit_in,
    axis5_minus_limit_in,
    axis5_plus_limit_in,
    aux_lock_led,
    single_block_led,
    dry_run_led,
    opt_stop_led,
    aux_lock_act,
    single_block_act,
    dry_run_act,
    prog_hold,
    estop_alarm,
    overtravel_alarm,
    drive_enable_out,
    sys_reset_pulse,
    cursor_home_pulse,
    beacon_yellow,
    beacon_green,
    beacon_red
);
    input  wire                   clk_sys;
    input  wire                   rst_b;
    input  wire [`MPL_ADDR_W-1:0] reg_addr;
    input  wire [7:0]             reg_wdata;
    input  wire                   reg_wr;
    input  wire                   reg_rd;
    output wire [7:0]             reg_rdata;
    output wire                   irq;
    input  wire                   mode_auto;
    input  wire                   mode_mdi;
    input  wire                   mode_dnc;
    input  wire                   prog_running;
    input  wire                   m01_exec;
    input  wire [4:0]             axis_dir_neg;
    input  wire                   key_aux_lock;
    input  wire                   key_single_block;
    input  wire                   key_dry_run;
    input  wire                   key_opt_stop;
    input  wire                   key_cycle_start;
    input  wire                   key_reset;
    input  wire                   ext_estop_in;
    input  wire                   x_minus_limit_in;
    input  wire                   x_plus_limit_in;
    input  wire                   y_minus_limit_in;
    input  wire                   y_plus_limit_in;
    input  wire                   z_minus_limit_in;
    input  wire                   z_plus_limit_in;
    input  wire                   axis4_minus_limit_in;
    input  wire                   axis4_plus_limit_in;
    input  wire                   axis5_minus_limit_in;
    input  wire                   axis5_plus_limit_in;
    output wire                   aux_lock_led;
    output wire                   single_block_led;
    output wire                   dry_run_led;
    output wire                   opt_stop_led;
    output wire                   aux_lock_act;
    output wire                   single_block_act;
    output wire                   dry_run_act;
    output wire                   prog_hold;
    output wire                   estop_alarm;
    output wire                   overtravel_alarm;
    output wire                   drive_enable_out;
    output wire                   sys_reset_pulse;
    output wire                   cursor_home_pulse;
    output wire                   beacon_yellow;
    output wire                   beacon_green;
    output wire                   beacon_red;

    // Pin synchronisation: 6 keys, estop, 10 limits
    wire [16:0] pins_raw;
    wire [16:0] pins_s;
    assign pins_raw = {axis5_plus_limit_in, axis5_minus_limit_in, axis4_plus_limit_in, axis4_minus_limit_in,
                       z_plus_limit_in, z_minus_limit_in, y_plus_limit_in, y_minus_limit_in,
                       x_plus_limit_in, x_minus_limit_in, ~ext_estop_in,
                       key_reset, key_cycle_start, key_opt_stop, key_dry_run, key_single_block, key_aux_lock};

    mpl_sync #(.W(17)) u_sync (
        .clk_sys (clk_sys),
        .rst_b   (rst_b),
        .d_in    (pins_raw),
        .q_out   (pins_s)
    );

    wire [5:0] keys_s;
    assign keys_s = pins_s[5:0];
    wire       estop_s;
    // Carried inverted so the cleared synchroniser reads a closed loop, no false trip after reset
    assign estop_s = ~pins_s[6];

    reg  [5:0] keys_d_ff;
    wire [5:0] key_press;
    assign key_press = keys_s & ~keys_d_ff;

    reg  [7:0]            ot_cfg_ff;
    reg  [7:0]            rst_cfg_ff;
    reg  [7:0]            ctrl_ff;
    reg  [`MPL_IRQ_W-1:0] irq_stat_ff;
    reg  [`MPL_IRQ_W-1:0] irq_mask_ff;
    reg  [7:0]            rdata_ff;
    reg                   aux_ff;
    reg                   sblk_ff;
    reg                   dry_ff;
    reg                   opt_ff;
    reg                   hold_ff;
    reg                   estop_ff;
    reg                   rst_pulse_ff;
    reg                   home_pulse_ff;

    wire auto_like;
    assign auto_like = mode_auto | mode_mdi | mode_dnc;

    // Mode key toggles
    always @(posedge clk_sys) begin
        if (!rst_b) begin
            keys_d_ff <= 6'h0;
            aux_ff    <= 1'b0;
            sblk_ff   <= 1'b0;
            dry_ff    <= 1'b0;
            opt_ff    <= 1'b0;
        end else begin
            keys_d_ff <= keys_s;
            if (key_press[0])
                aux_ff <= ~aux_ff;
            if (key_press[1])
                sblk_ff <= ~sblk_ff;
            // Ignoring the key while running keeps feed rate stable mid-program
            if (key_press[2] && !prog_running)
                dry_ff <= ~dry_ff;
            if (key_press[3] && auto_like)
                opt_ff <= ~opt_ff;
        end
    end

    assign aux_lock_led     = aux_ff;
    assign single_block_led = sblk_ff;
    assign dry_run_led      = dry_ff;
    assign opt_stop_led     = opt_ff;
    assign aux_lock_act     = aux_ff & auto_like;
    assign single_block_act = sblk_ff & auto_like;
    assign dry_run_act      = dry_ff & auto_like;

    // Optional stop hold
    wire m01_hit;
    assign m01_hit = m01_exec & opt_ff & auto_like;
    always @(posedge clk_sys) begin
        if (!rst_b)
            hold_ff <= 1'b0;
        else if (m01_hit)
            hold_ff <= 1'b1;
        else if (key_press[4])
            hold_ff <= 1'b0;
    end
    assign prog_hold = hold_ff;

    // Emergency stop: input low means the +24V loop is open
    wire estop_trip;
    assign estop_trip = !estop_s && !ctrl_ff[`MPL_CTRL_ESTOP_IGN];
    always @(posedge clk_sys) begin
        if (!rst_b)
            estop_ff <= 1'b0;
        else
            estop_ff <= estop_trip;
    end
    assign estop_alarm      = estop_ff;
    assign drive_enable_out = !estop_ff;

    // Reset key gating
    wire reset_key_ok;
    assign reset_key_ok = key_press[5] & rst_cfg_ff[`MPL_RST_EN_BIT];
    always @(posedge clk_sys) begin
        if (!rst_b) begin
            rst_pulse_ff  <= 1'b0;
            home_pulse_ff <= 1'b0;
        end else begin
            rst_pulse_ff  <= reset_key_ok;
            home_pulse_ff <= reset_key_ok & mode_auto;
        end
    end
    assign sys_reset_pulse   = rst_pulse_ff;
    assign cursor_home_pulse = home_pulse_ff;

    // Overtravel supervision
    wire [1:0] lim_sel;
    assign lim_sel = {ot_cfg_ff[`MPL_OT_SEL_HI_BIT], ot_cfg_ff[`MPL_OT_SEL_LO_BIT]};
    // Polarity 1 means open circuit alarms, so alarm level is 0
    wire lvl_xyz;
    assign lvl_xyz = !ot_cfg_ff[`MPL_OT_POL_BIT];
    wire [4:0] ax_en;
    assign ax_en = {ot_cfg_ff[`MPL_OT_AX5_BIT], ot_cfg_ff[`MPL_OT_AX4_BIT],
                    {3{ot_cfg_ff[`MPL_OT_XYZ_BIT]}}};
    wire [4:0] ax_alarm;

    genvar gi;
    generate
        for (gi = 0; gi < 5; gi = gi + 1) begin : g_axis
            mpl_axis_limit u_lim (
                .clk_sys      (clk_sys),
                .rst_b        (rst_b),
                .mode_sel     (lim_sel),
                .axis_en      (ax_en[gi]),
                .alarm_level  (gi < 3 ? lvl_xyz : 1'b0),
                .minus_in     (pins_s[7+2*gi]),
                .plus_in      (gi == 0 || lim_sel != `MPL_LIM_COMB ? pins_s[8+2*gi] : pins_s[7+2*gi]),
                .move_dir_neg (axis_dir_neg[gi]),
                .clear        (reset_key_ok),
                .alarm        (ax_alarm[gi])
            );
        end
    endgenerate
    assign overtravel_alarm = |ax_alarm;

    // Beacon
    wire any_alarm;
    assign any_alarm     = estop_ff | overtravel_alarm;
    assign beacon_red    = any_alarm;
    assign beacon_green  = !any_alarm && mode_auto && prog_running;
    assign beacon_yellow = !any_alarm && !(mode_auto && prog_running);

    // Register port and sticky interrupt status
    reg  [4:0] ax_alarm_d_ff;
    wire [`MPL_IRQ_W-1:0] ev_all;
    assign ev_all = {reset_key_ok, m01_hit, |(ax_alarm & ~ax_alarm_d_ff), estop_trip & !estop_ff};

    always @(posedge clk_sys) begin
        if (!rst_b) begin
            ot_cfg_ff     <= `MPL_OT_CFG_RST;
            rst_cfg_ff    <= `MPL_RST_CFG_RST;
            ctrl_ff       <= `MPL_CTRL_RST;
            irq_mask_ff   <= {`MPL_IRQ_W{1'b0}};
            irq_stat_ff   <= {`MPL_IRQ_W{1'b0}};
            ax_alarm_d_ff <= 5'h0;
            rdata_ff      <= 8'h00;
        end else begin
            ax_alarm_d_ff <= ax_alarm;
            if (reg_wr) begin
                if (reg_addr == `MPL_OFS_OT_CFG)
                    ot_cfg_ff <= reg_wdata;
                else if (reg_addr == `MPL_OFS_RST_CFG)
                    rst_cfg_ff <= reg_wdata;
                else if (reg_addr == `MPL_OFS_CTRL)
                    ctrl_ff <= reg_wdata;
                else if (reg_addr == `MPL_OFS_IRQ_MASK)
                    irq_mask_ff <= reg_wdata[`MPL_IRQ_W-1:0];
            end
            // New event wins over a write-one clear in the same cycle
            if (reg_wr && reg_addr == `MPL_OFS_IRQ_STAT)
                irq_stat_ff <= (irq_stat_ff & ~reg_wdata[`MPL_IRQ_W-1:0]) | ev_all;
            else
                irq_stat_ff <= irq_stat_ff | ev_all;
            rdata_ff <= 8'h00;
            if (reg_rd) begin
                if (reg_addr == `MPL_OFS_OT_CFG)
                    rdata_ff <= ot_cfg_ff;
                else if (reg_addr == `MPL_OFS_RST_CFG)
                    rdata_ff <= rst_cfg_ff;
                else if (reg_addr == `MPL_OFS_CTRL)
                    rdata_ff <= ctrl_ff;
                else if (reg_addr == `MPL_OFS_STATUS)
                    rdata_ff <= {overtravel_alarm ? ax_alarm : 5'h0, hold_ff, !estop_ff, estop_ff};
                else if (reg_addr == `MPL_OFS_IRQ_STAT)
                    rdata_ff <= {4'h0, irq_stat_ff};
                else if (reg_addr == `MPL_OFS_IRQ_MASK)
                    rdata_ff <= {4'h0, irq_mask_ff};
                else if (reg_addr == `MPL_OFS_MODES)
                    rdata_ff <= {4'h0, opt_ff, dry_ff, sblk_ff, aux_ff};
            end
        end
    end

    assign reg_rdata = rdata_ff;
    assign irq       = |(irq_stat_ff & irq_mask_ff);
endmodule // mpl_panel_top

// file: logic/mpl_defines.vh
// Register map, field positions and reset values of the machine panel block.
// Included by every file of the block.
`ifndef MPL_DEFINES_VH
`define MPL_DEFINES_VH
`define MPL_ADDR_W          4
`define MPL_OFS_OT_CFG      4'h0
`define MPL_OFS_RST_CFG     4'h1
`define MPL_OFS_CTRL        4'h2
`define MPL_OFS_STATUS      4'h3
`define MPL_OFS_IRQ_STAT    4'h4
`define MPL_OFS_IRQ_MASK    4'h5
`define MPL_OFS_MODES       4'h6
`define MPL_OT_POL_BIT      0
`define MPL_OT_XYZ_BIT      1
`define MPL_OT_AX4_BIT      3
`define MPL_OT_AX5_BIT      4
`define MPL_OT_SEL_LO_BIT   6
`define MPL_OT_SEL_HI_BIT   7
`define MPL_RST_EN_BIT      0
`define MPL_CTRL_ESTOP_IGN  0
`define MPL_OT_CFG_RST      8'h00
`define MPL_RST_CFG_RST     8'h01
`define MPL_CTRL_RST        8'h00
`define MPL_IRQ_ESTOP       0
`define MPL_IRQ_OT          1
`define MPL_IRQ_M01         2
`define MPL_IRQ_RESET       3
`define MPL_IRQ_W           4
`define MPL_LIM_OFF         2'b00
`define MPL_LIM_COMB        2'b01
`define MPL_LIM_SEP         2'b10
`define MPL_SYNC_STAGES     2
`endif

// file: logic/mpl_sync.v
// Two flip-flop synchroniser for a bus of asynchronous pin levels.
// Assumes pins are slow levels; no glitch filtering is done here.
`include "mpl_defines.vh"
module mpl_sync #(
    parameter W = 1
) (
    clk_sys,
    rst_b,
    d_in,
    q_out
);
    input  wire         clk_sys;
    input  wire         rst_b;
    input  wire [W-1:0] d_in;
    output wire [W-1:0] q_out;

    reg [W-1:0] meta_ff;
    reg [W-1:0] sync_ff;

    always @(posedge clk_sys) begin
        if (!rst_b) begin
            meta_ff <= {W{1'b0}};
            sync_ff <= {W{1'b0}};
        end else begin
            meta_ff <= d_in;
            sync_ff <= meta_ff;
        end
    end

    assign q_out = sync_ff;
endmodule // mpl_sync

// file: logic/mpl_axis_limit.v
// Overtravel detection of one axis in separate or combined limit mode.
// Assumes inputs are already synchronised; alarm is a sticky latch cleared by the caller's reset key.
`include "mpl_defines.vh"
module mpl_axis_limit (
    clk_sys,
    rst_b,
    mode_sel,
    axis_en,
    alarm_level,
    minus_in,
    plus_in,
    move_dir_neg,
    clear,
    alarm
);
    input  wire       clk_sys;
    input  wire       rst_b;
    input  wire [1:0] mode_sel;
    input  wire       axis_en;
    input  wire       alarm_level;
    input  wire       minus_in;
    input  wire       plus_in;
    input  wire       move_dir_neg;
    input  wire       clear;
    output wire       alarm;

    reg  alarm_ff;
    reg  nxt_alarm;
    wire hit_minus;
    wire hit_plus;
    wire trip;

    assign hit_minus = (minus_in == alarm_level);
    assign hit_plus  = (plus_in == alarm_level);
    // Combined mode: single input on plus_in, direction of motion not used
    assign trip = axis_en &&
                  ((mode_sel == `MPL_LIM_SEP  && (hit_minus || hit_plus)) ||
                   (mode_sel == `MPL_LIM_COMB && hit_plus));

    always @* begin
        nxt_alarm = alarm_ff;
        // Clear only once input has returned; an active trip wins over clear
        if (trip)
            nxt_alarm = 1'b1;
        else if (clear)
            nxt_alarm = 1'b0;
    end

    always @(posedge clk_sys) begin
        if (!rst_b)
            alarm_ff <= 1'b0;
        else
            alarm_ff <= nxt_alarm;
    end

    assign alarm = alarm_ff;

    wire unused_dir = move_dir_neg;
endmodule // mpl_axis_limit

// file: verif/mpl_chk_sva.sv
// Checker of the machine panel block, watching the top module ports only.
// Assumes one clock domain and the synchronous active-low reset.
module mpl_chk (
    input wire logic       clk_sys,
    input wire logic       rst_b,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic       mode_auto,
    input wire logic       mode_mdi,
    input wire logic       mode_dnc,
    input wire logic       prog_running,
    input wire logic       m01_exec,
    input wire logic       aux_lock_led,
    input wire logic       aux_lock_act,
    input wire logic       single_block_led,
    input wire logic       single_block_act,
    input wire logic       dry_run_led,
    input wire logic       dry_run_act,
    input wire logic       opt_stop_led,
    input wire logic       prog_hold,
    input wire logic       estop_alarm,
    input wire logic       overtravel_alarm,
    input wire logic       drive_enable_out,
    input wire logic       sys_reset_pulse,
    input wire logic       cursor_home_pulse,
    input wire logic       beacon_yellow,
    input wire logic       beacon_green,
    input wire logic       beacon_red
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    wire auto_like = mode_auto | mode_mdi | mode_dnc;
    wire any_alarm = estop_alarm | overtravel_alarm;
    aux_act_a: assert property (aux_lock_act == (aux_lock_led & auto_like))
        else $error("aux lock action wrong");
    sblk_act_a: assert property (single_block_act == (single_block_led & auto_like))
        else $error("single block action wrong");
    dry_act_a: assert property (dry_run_act == (dry_run_led & auto_like))
        else $error("dry run action wrong");
    dry_frozen_a: assert property (prog_running |=> $stable(dry_run_led))
        else $error("dry run changed while running");
    m01_hold_a: assert property (m01_exec && opt_stop_led && auto_like |=> prog_hold)
        else $error("optional stop did not hold");
    drive_off_a: assert property (drive_enable_out == !estop_alarm)
        else $error("drive enable not tied to emergency");
    beacon_red_a: assert property (beacon_red == any_alarm)
        else $error("red beacon wrong");
    beacon_mix_a: assert property (beacon_green == (!any_alarm & mode_auto & prog_running)
        && beacon_yellow == !(any_alarm | beacon_green)) else $error("green or yellow beacon wrong");
    rst_pulse_a: assert property (sys_reset_pulse |=> !sys_reset_pulse)
        else $error("reset pulse longer than one cycle");
    cursor_home_a: assert property (cursor_home_pulse |-> sys_reset_pulse)
        else $error("cursor return without reset");
    ot_clear_a: assert property ($fell(overtravel_alarm) |-> sys_reset_pulse || $past(sys_reset_pulse))
        else $error("overtravel cleared without reset key");
    rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside its cycle");
    cover property (prog_hold);
    cover property ($rose(estop_alarm));
    cover property ($rose(overtravel_alarm));
    cover property (cursor_home_pulse);
endmodule // mpl_chk

// file: verif/mpl_pins_model.sv
// Model of the panel keys, limit switches and emergency switch.
// Assumes one clock; every pin changes just after a rising edge.
module mpl_pins_model (
    input  wire logic  clk_sys,
    output logic [5:0] keys,
    output logic [9:0] lim,
    output logic       estop_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // Keys rest open; switches rest closed to +24V
    initial begin
        keys = 6'h00;
        lim = 10'h3ff;
        estop_in = 1'b1;
    end
    // Held four cycles so the press survives the two-stage synchroniser
    task automatic press(input int k);
        @(posedge clk_sys);
        keys[k] <= 1'b1;
        repeat (4) @(posedge clk_sys);
        keys[k] <= 1'b0;
        repeat (4) @(posedge clk_sys);
    endtask
    task automatic set_lim(input logic [9:0] v);
        @(posedge clk_sys);
        lim <= v;
    endtask
    task automatic set_estop(input logic v);
        @(posedge clk_sys);
        estop_in <= v;
    endtask
endmodule // mpl_pins_model

// file: verif/tb.sv
// Self-checking bench of the machine panel block.
// Drives the register port and core inputs; the pin model drives keys and switches.
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] CFG [10] = '{8'h83, 8'h83, 8'h43, 8'h03, 8'hc3, 8'h81, 8'h82, 8'h89, 8'h81, 8'h91};
    localparam logic [9:0] PIN [10] = '{10'h3fe, 10'h3fd, 10'h3fd, 10'h3fe, 10'h3fe, 10'h3fe, 10'h3c4, 10'h3bf,
                                        10'h3bf, 10'h2ff};
    localparam logic [9:0] EXP = 10'h2c7;
    logic       clk_sys = 1'b0;
    logic       rst_b = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic       reg_wr = 1'b0;
    logic       reg_rd = 1'b0;
    logic [2:0] modes = 3'h0;
    logic       prog_running = 1'b0;
    logic       m01_exec = 1'b0;
    logic [4:0] dir_neg = 5'h00;
    wire  [7:0] reg_rdata;
    wire  [5:0] keys;
    wire  [9:0] lim;
    wire        estop_in, irq, aux_lock_led, single_block_led, dry_run_led, opt_stop_led, aux_lock_act;
    wire        single_block_act, dry_run_act, prog_hold, estop_alarm, overtravel_alarm, drive_enable_out;
    wire        sys_reset_pulse, cursor_home_pulse, beacon_yellow, beacon_green, beacon_red;
    int         miscompares = 0;
    int         n_compared = 0;
    int         n_rst = 0;
    int         n_cur = 0;
    mpl_pins_model mp (.clk_sys(clk_sys), .keys(keys), .lim(lim), .estop_in(estop_in));
    mpl_panel_top uut (
        .clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq), .mode_auto(modes[0]), .mode_mdi(modes[1]),
        .mode_dnc(modes[2]), .prog_running(prog_running), .m01_exec(m01_exec), .axis_dir_neg(dir_neg),
        .key_aux_lock(keys[0]), .key_single_block(keys[1]), .key_dry_run(keys[2]), .key_opt_stop(keys[3]),
        .key_cycle_start(keys[4]), .key_reset(keys[5]), .ext_estop_in(estop_in), .x_minus_limit_in(lim[0]),
        .x_plus_limit_in(lim[1]), .y_minus_limit_in(lim[2]), .y_plus_limit_in(lim[3]), .z_minus_limit_in(lim[4]),
        .z_plus_limit_in(lim[5]), .axis4_minus_limit_in(lim[6]), .axis4_plus_limit_in(lim[7]),
        .axis5_minus_limit_in(lim[8]), .axis5_plus_limit_in(lim[9]), .aux_lock_led(aux_lock_led),
        .single_block_led(single_block_led), .dry_run_led(dry_run_led), .opt_stop_led(opt_stop_led),
        .aux_lock_act(aux_lock_act), .single_block_act(single_block_act), .dry_run_act(dry_run_act),
        .prog_hold(prog_hold), .estop_alarm(estop_alarm), .overtravel_alarm(overtravel_alarm),
        .drive_enable_out(drive_enable_out), .sys_reset_pulse(sys_reset_pulse),
        .cursor_home_pulse(cursor_home_pulse), .beacon_yellow(beacon_yellow), .beacon_green(beacon_green),
        .beacon_red(beacon_red)
    );
    initial begin
        forever #5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        if (sys_reset_pulse === 1'b1) n_rst++;
        if (cursor_home_pulse === 1'b1) n_cur++;
    end
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            miscompares++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chb(input string nm, input logic e, input logic g);
        chk(nm, {7'h00, e}, {7'h00, g});
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e, input string nm);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 chk(nm, e, reg_rdata);
    endtask
    task automatic wrap_up;
        $display("Counts: %0d compared, %0d miscompares", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        #200000;
        miscompares++;
        wrap_up;
    end
    initial begin
        repeat (12) @(posedge clk_sys);
        rst_b <= 1'b1;
        rd(4'h0, 8'h00, "overtravel_config");
        rd(4'h1, 8'h01, "reset_key_config");
        rd(4'h3, 8'h02, "status");
        rd(4'h6, 8'h00, "modes");
        wr(4'hf, 8'hff);
        rd(4'hf, 8'h00, "unmapped");
        wr(4'h0, 8'hff);
        rd(4'h0, 8'hff, "overtravel_config rw");
        $display("Test registers done");
        mp.press(0);
        mp.press(1);
        mp.press(2);
        chk("leds", 8'h07, {5'h00, dry_run_led, single_block_led, aux_lock_led});
        chk("acts idle", 8'h00, {5'h00, dry_run_act, single_block_act, aux_lock_act});
        for (int m = 0; m < 3; m++) begin
            @(posedge clk_sys);
            modes <= 3'h1 << m;
            cyc(1);
            chk("acts", 8'h07, {5'h00, dry_run_act, single_block_act, aux_lock_act});
        end
        mp.press(3);
        chb("opt led", 1'b1, opt_stop_led);
        @(posedge clk_sys);
        modes <= 3'h0;
        mp.press(3);
        chb("opt led idle", 1'b1, opt_stop_led);
        prog_running <= 1'b1;
        mp.press(2);
        chb("dry frozen", 1'b1, dry_run_led);
        prog_running <= 1'b0;
        mp.press(2);
        chb("dry toggle", 1'b0, dry_run_led);
        rd(4'h6, 8'h0b, "modes");
        $display("Test mode keys done");
        @(posedge clk_sys);
        modes <= 3'h1;
        prog_running <= 1'b1;
        m01_exec <= 1'b1;
        @(posedge clk_sys);
        m01_exec <= 1'b0;
        cyc(2);
        chk("beacons run", 8'h02, {5'h00, beacon_red, beacon_green, beacon_yellow});
        chb("hold", 1'b1, prog_hold);
        mp.press(4);
        chb("hold released", 1'b0, prog_hold);
        prog_running <= 1'b0;
        $display("Test optional stop done");
        wr(4'h4, 8'hff);
        wr(4'h5, 8'h0f);
        mp.set_estop(1'b0);
        cyc(5);
        chk("estop", 8'h05, {5'h00, beacon_red, drive_enable_out, estop_alarm});
        chb("irq", 1'b1, irq);
        rd(4'h3, 8'h01, "status estop");
        rd(4'h4, 8'h01, "irq status");
        wr(4'h5, 8'h00);
        cyc(1);
        chb("irq masked", 1'b0, irq);
        wr(4'h2, 8'h01);
        cyc(3);
        chb("estop ignored", 1'b0, estop_alarm);
        wr(4'h2, 8'h00);
        cyc(3);
        chb("estop acted", 1'b1, estop_alarm);
        mp.set_estop(1'b1);
        wr(4'h5, 8'h0f);
        cyc(4);
        chb("irq sticky", 1'b1, irq);
        wr(4'h4, 8'hff);
        cyc(1);
        chb("irq cleared", 1'b0, irq);
        $display("Test emergency stop done");
        for (int i = 0; i < 10; i++) begin
            wr(4'h0, 8'h00);
            mp.set_lim(CFG[i][0] ? 10'h3ff : 10'h3c0);
            cyc(4);
            wr(4'h0, CFG[i]);
            dir_neg <= ~dir_neg;
            mp.set_lim(PIN[i]);
            cyc(5);
            chb("overtravel", EXP[i], overtravel_alarm);
            mp.press(5);
            chb("trip wins", EXP[i], overtravel_alarm);
            mp.set_lim(CFG[i][0] ? 10'h3ff : 10'h3c0);
            cyc(4);
            mp.press(5);
            chb("cleared", 1'b0, overtravel_alarm);
        end
        chk("cursor count", 8'd20, n_cur[7:0]);
        @(posedge clk_sys);
        modes <= 3'h2;
        mp.press(5);
        chk("counts mdi", 8'h54, {n_rst[3:0], n_cur[3:0]});
        wr(4'h1, 8'h00);
        mp.set_lim(10'h2ff);
        cyc(5);
        mp.set_lim(10'h3ff);
        cyc(4);
        mp.press(5);
        chb("reset off", 1'b1, overtravel_alarm);
        chk("pulses off", 8'd21, n_rst[7:0]);
        wr(4'h1, 8'h01);
        mp.press(5);
        chb("reset on", 1'b0, overtravel_alarm);
        $display("Test overtravel done");
        wrap_up;
    end
endmodule // tb
bind mpl_panel_top mpl_chk chk_i (
    .clk_sys(clk_sys), .rst_b(rst_b), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mode_auto(mode_auto),
    .mode_mdi(mode_mdi), .mode_dnc(mode_dnc), .prog_running(prog_running), .m01_exec(m01_exec),
    .aux_lock_led(aux_lock_led), .aux_lock_act(aux_lock_act), .single_block_led(single_block_led),
    .single_block_act(single_block_act), .dry_run_led(dry_run_led), .dry_run_act(dry_run_act),
    .opt_stop_led(opt_stop_led), .prog_hold(prog_hold), .estop_alarm(estop_alarm),
    .overtravel_alarm(overtravel_alarm), .drive_enable_out(drive_enable_out), .sys_reset_pulse(sys_reset_pulse),
    .cursor_home_pulse(cursor_home_pulse), .beacon_yellow(beacon_yellow), .beacon_green(beacon_green),
    .beacon_red(beacon_red)
);
